// [hdl/status_indicators.sv]
// status lamps and two-digit display driver with register port
// assumes status inputs are synchronous to core_clk_i
module status_indicators
	import indicator_pkg::*;
#(
	parameter int unsigned HALF_CYCLES = FLASH_HALF_CYCLES
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// status inputs
	input  wire op_mode_t    mode_i,
	input  wire logic        debug_running_i,
	input  wire logic        fatal_fault_i,
	input  wire logic        prog_halt_err_i,
	input  wire logic        prog_local_err_i,
	input  wire logic        validated_i,
	input  wire logic        sig_confirmed_i,
	input  wire logic [7:0]  sig_byte_i,
	input  wire logic        conn_pending_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// interrupt
	output logic             irq_o,
	// lamps
	output logic             perr_lamp_o,
	output logic             run_lamp_o,
	output logic             debug_lamp_o,
	output logic             valid_lamp_o,
	// display
	output logic      [6:0]  seg_hi_o,
	output logic      [6:0]  seg_lo_o
);

	// ***************************************************
	// shared timebase
	// ***************************************************
	flash_if fl ();

	flash_timebase #(
		.HALF_CYCLES (HALF_CYCLES)
	) u_timebase (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.fl         (fl)
	);

	wire phase;

	assign phase = fl.phase;

	// ***************************************************
	// lamp decode
	// ***************************************************
	logic perr_d;
	logic run_d;
	logic debug_d;
	logic valid_d;

	always_comb begin
		if (prog_halt_err_i) begin
			perr_d = 1'b1;
		end else if (prog_local_err_i) begin
			perr_d = phase;
		end else begin
			perr_d = 1'b0;
		end
	end

	always_comb begin
		run_d   = 1'b0;
		debug_d = 1'b0;
		if (!fatal_fault_i) begin
			case (mode_i)
				MODE_INIT:    run_d = phase;
				MODE_RUN:     run_d = 1'b1;
				MODE_PROGRAM: run_d = 1'b0;
				MODE_DEBUG: begin
					run_d   = debug_running_i;
					debug_d = 1'b1;
				end
				default:      run_d = 1'b0;
			endcase
		end
	end

	assign valid_d = validated_i && !fatal_fault_i;

	// ***************************************************
	// display decode
	// ***************************************************
	logic       blank_q;
	wire  [6:0] dig_hi;
	wire  [6:0] dig_lo;
	wire        disp_dark;
	wire  [6:0] seg_hi_d;
	wire  [6:0] seg_lo_d;

	assign dig_hi    = sig_confirmed_i ? hex_to_seg(sig_byte_i[7:4]) : SEG_DASH;
	assign dig_lo    = sig_confirmed_i ? hex_to_seg(sig_byte_i[3:0]) : SEG_DASH;
	assign disp_dark = blank_q || (conn_pending_i && !phase);
	assign seg_hi_d  = disp_dark ? SEG_BLANK : dig_hi;
	assign seg_lo_d  = disp_dark ? SEG_BLANK : dig_lo;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			perr_lamp_o  <= 1'b0;
			run_lamp_o   <= 1'b0;
			debug_lamp_o <= 1'b0;
			valid_lamp_o <= 1'b0;
			seg_hi_o     <= SEG_BLANK;
			seg_lo_o     <= SEG_BLANK;
		end else begin
			perr_lamp_o  <= perr_d;
			run_lamp_o   <= run_d;
			debug_lamp_o <= debug_d;
			valid_lamp_o <= valid_d;
			seg_hi_o     <= seg_hi_d;
			seg_lo_o     <= seg_lo_d;
		end
	end

	// ***************************************************
	// events
	// ***************************************************
	logic       halt_q;
	logic       local_q;
	logic       fatal_q;
	logic       pend_q;
	op_mode_t   mode_q;
	wire  [EVT_W-1:0] evt_set;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			halt_q  <= 1'b0;
			local_q <= 1'b0;
			fatal_q <= 1'b0;
			pend_q  <= 1'b0;
			mode_q  <= MODE_INIT;
		end else begin
			halt_q  <= prog_halt_err_i;
			local_q <= prog_local_err_i;
			fatal_q <= fatal_fault_i;
			pend_q  <= conn_pending_i;
			mode_q  <= mode_i;
		end
	end

	assign evt_set[EVT_HALT]    = prog_halt_err_i && !halt_q;
	assign evt_set[EVT_LOCAL]   = prog_local_err_i && !local_q;
	assign evt_set[EVT_FATAL]   = fatal_fault_i && !fatal_q;
	assign evt_set[EVT_CONN_UP] = !conn_pending_i && pend_q;
	assign evt_set[EVT_MODE]    = mode_i != mode_q;

	// ***************************************************
	// register port
	// ***************************************************
	logic [EVT_W-1:0] evt_q;
	logic [EVT_W-1:0] evt_d;
	logic [EVT_W-1:0] mask_q;
	logic [EVT_W-1:0] mask_d;
	logic             blank_d;
	wire              wr_evt;
	wire              wr_mask;
	wire              wr_ctrl;
	wire  [31:0]      status_word;
	logic [31:0]      rdata_d;

	assign wr_evt  = wr_i && (addr_i == REG_EVENT);
	assign wr_mask = wr_i && (addr_i == REG_MASK);
	assign wr_ctrl = wr_i && (addr_i == REG_CTRL);

	// set wins over a write-one clear in the same cycle
	assign evt_d   = (evt_q & ~(wr_evt ? wdata_i[EVT_W-1:0] : '0)) | evt_set;
	assign mask_d  = wr_mask ? wdata_i[EVT_W-1:0] : mask_q;
	assign blank_d = wr_ctrl ? wdata_i[CTRL_BLANK] : blank_q;

	assign status_word = {8'h00, seg_hi_o[6:0], 1'b0, sig_byte_i, 1'b0, phase,
		mode_q, valid_lamp_o, debug_lamp_o, run_lamp_o, perr_lamp_o};

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				REG_STATUS: rdata_d = status_word;
				REG_EVENT:  rdata_d = {{(32 - EVT_W){1'b0}}, evt_q};
				REG_MASK:   rdata_d = {{(32 - EVT_W){1'b0}}, mask_q};
				REG_CTRL:   rdata_d = {31'h0000_0000, blank_q};
				default:    rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			evt_q   <= EVT_RESET;
			mask_q  <= MASK_RESET;
			blank_q <= CTRL_RESET;
			irq_o   <= 1'b0;
			rdata_o <= 32'h0000_0000;
		end else begin
			evt_q   <= evt_d;
			mask_q  <= mask_d;
			blank_q <= blank_d;
			irq_o   <= |(evt_d & mask_d);
			rdata_o <= rdata_d;
		end
	end

	// ***************************************************
	// checks
	// ***************************************************
	logic rst_hold_q;

	// keeps checks quiet on the edge that releases reset
	always_ff @(posedge core_clk_i) begin
		rst_hold_q <= rst_i;
	end

	sequence s_init_flash;
		!fatal_fault_i && mode_i == MODE_INIT;
	endsequence

	sequence s_halted;
		prog_halt_err_i;
	endsequence

	sequence s_local_only;
		prog_local_err_i && !prog_halt_err_i;
	endsequence

	sequence s_executing;
		!fatal_fault_i && (mode_i == MODE_RUN || (mode_i == MODE_DEBUG && debug_running_i));
	endsequence

	sequence s_run_off;
		fatal_fault_i || mode_i == MODE_PROGRAM || (mode_i == MODE_DEBUG && !debug_running_i);
	endsequence

	sequence s_pending_dark;
		!blank_q && conn_pending_i && !phase;
	endsequence

	chk_perr_steady: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_halted |=> perr_lamp_o
	) else $error("error lamp not steady on halt");

	chk_perr_flash: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_local_only |=> perr_lamp_o == $past(phase)
	) else $error("error lamp not following flash phase");

	chk_perr_dark: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		!prog_halt_err_i && !prog_local_err_i |=> !perr_lamp_o
	) else $error("error lamp lit without error");

	chk_run_steady: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_executing |=> run_lamp_o
	) else $error("run lamp dark while executing");

	chk_run_init_flash: assert property (
		@(posedge core_clk_i) disable iff (rst_i || rst_hold_q)
		s_init_flash |=> run_lamp_o == $past(phase)
	) else $error("run lamp not flashing in init");

	chk_run_off: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_run_off |=> !run_lamp_o
	) else $error("run lamp lit when it must be off");

	chk_debug_lit: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		!fatal_fault_i && mode_i == MODE_DEBUG |=> debug_lamp_o
	) else $error("debug lamp dark in debug mode");

	chk_debug_dark: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		fatal_fault_i || mode_i != MODE_DEBUG |=> !debug_lamp_o
	) else $error("debug lamp lit outside debug mode");

	chk_valid_lit: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		validated_i && !fatal_fault_i |=> valid_lamp_o
	) else $error("validation lamp dark with validated data");

	chk_valid_dark: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		!validated_i || fatal_fault_i |=> !valid_lamp_o
	) else $error("validation lamp lit without validated data");

	chk_sig_shown: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		!blank_q && !conn_pending_i && sig_confirmed_i
		|=> seg_hi_o == hex_to_seg($past(sig_byte_i[7:4]))
			&& seg_lo_o == hex_to_seg($past(sig_byte_i[3:0]))
	) else $error("display not showing signature byte");

	chk_sig_dash: assert property (
		@(posedge core_clk_i) disable iff (rst_i || rst_hold_q)
		!blank_q && !conn_pending_i && !sig_confirmed_i
		|=> seg_hi_o == SEG_DASH && seg_lo_o == SEG_DASH
	) else $error("display not showing dash pattern");

	chk_disp_flash: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_pending_dark |=> seg_hi_o == SEG_BLANK && seg_lo_o == SEG_BLANK
	) else $error("display not dark in flash off half");

	chk_flash_phase: assert property (
		@(posedge core_clk_i) disable iff (rst_i || rst_hold_q)
		s_local_only ##0 s_init_flash |=> perr_lamp_o == run_lamp_o
	) else $error("flash not taken from the shared phase");

	chk_fatal_prio: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		fatal_fault_i [*2] |=> !run_lamp_o && !debug_lamp_o && !valid_lamp_o
	) else $error("fatal fault did not override lamps");

	chk_evt_sticky: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		evt_set[EVT_FATAL] |=> evt_q[EVT_FATAL]
	) else $error("fatal event not latched");

	chk_irq_level: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		##1 irq_o == |(evt_q & mask_q)
	) else $error("interrupt level disagrees with status and mask");

	chk_rdata_idle: assert property (
		@(posedge core_clk_i) disable iff (rst_i || rst_hold_q)
		!rd_i |=> rdata_o == 32'h0000_0000
	) else $error("read data not zero outside a read");

	chk_evt_hold: assert property (
		@(posedge core_clk_i) disable iff (rst_i || rst_hold_q)
		evt_q[EVT_HALT] && !(wr_evt && wdata_i[EVT_HALT]) |=> evt_q[EVT_HALT]
	) else $error("halt event bit lost without a clear");

endmodule

// [hdl/indicator_pkg.sv]
// constants, types and helpers for the status-indicator driver
// assumes a single 250 MHz clock and a synchronous active-high reset
package indicator_pkg;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int unsigned CLK_FREQ_HZ       = 250_000_000;
	localparam int unsigned FLASH_INTERVAL_S  = 1;
	localparam int unsigned FLASH_HALF_CYCLES = FLASH_INTERVAL_S * CLK_FREQ_HZ;

	// ***************************************************
	// register map
	// ***************************************************
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_EVENT  = 8'h04;
	localparam logic [7:0] REG_MASK   = 8'h08;
	localparam logic [7:0] REG_CTRL   = 8'h0C;

	localparam int unsigned EVT_W        = 5;
	localparam int unsigned EVT_HALT     = 0;
	localparam int unsigned EVT_LOCAL    = 1;
	localparam int unsigned EVT_FATAL    = 2;
	localparam int unsigned EVT_CONN_UP  = 3;
	localparam int unsigned EVT_MODE     = 4;

	localparam int unsigned CTRL_BLANK   = 0;

	localparam logic [EVT_W-1:0] EVT_RESET  = 5'h00;
	localparam logic [EVT_W-1:0] MASK_RESET = 5'h00;
	localparam logic             CTRL_RESET = 1'b0;

	// ***************************************************
	// display codes, segment order g f e d c b a
	// ***************************************************
	localparam logic [6:0] SEG_DASH  = 7'h40;
	localparam logic [6:0] SEG_BLANK = 7'h00;

	typedef enum logic [1:0] {
		MODE_INIT,
		MODE_RUN,
		MODE_PROGRAM,
		MODE_DEBUG
	} op_mode_t;

	function automatic logic [6:0] hex_to_seg(input logic [3:0] nib);
		logic [6:0] s;
		s = SEG_BLANK;
		case (nib)
			4'h0:    s = 7'h3F;
			4'h1:    s = 7'h06;
			4'h2:    s = 7'h5B;
			4'h3:    s = 7'h4F;
			4'h4:    s = 7'h66;
			4'h5:    s = 7'h6D;
			4'h6:    s = 7'h7D;
			4'h7:    s = 7'h07;
			4'h8:    s = 7'h7F;
			4'h9:    s = 7'h6F;
			4'hA:    s = 7'h77;
			4'hB:    s = 7'h7C;
			4'hC:    s = 7'h39;
			4'hD:    s = 7'h5E;
			4'hE:    s = 7'h79;
			default: s = 7'h71;
		endcase
		return s;
	endfunction

endpackage

// [hdl/flash_if.sv]
// shared flash phase between the timebase and the lamp logic
// assumes both ends run on the same clock
interface flash_if;
	logic phase;
	logic tick;

	modport src (output phase, output tick);
	modport snk (input phase, input tick);
endinterface

// [hdl/flash_timebase.sv]
// single flash timebase with equal on and off halves
// assumes the lamp logic samples phase on the same clock
module flash_timebase
	import indicator_pkg::*;
#(
	parameter int unsigned HALF_CYCLES = FLASH_HALF_CYCLES
) (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// flash phase out
	flash_if.src      fl
);

	localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

	logic [CW-1:0] cnt_q;
	wire           wrap;

	assign wrap = (cnt_q == CW'(HALF_CYCLES - 1));

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_q    <= '0;
			fl.phase <= 1'b1;
			fl.tick  <= 1'b0;
		end else begin
			cnt_q    <= wrap ? '0 : cnt_q + CW'(1);
			fl.phase <= wrap ? ~fl.phase : fl.phase;
			fl.tick  <= wrap;
		end
	end

	chk_phase_on_wrap: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		$changed(fl.phase) |-> fl.tick
	) else $error("flash phase changed without a wrap");

	chk_tick_toggles: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		wrap |=> $changed(fl.phase)
	) else $error("wrap did not toggle flash phase");

endmodule

// [tb/test_status_indicators.sv]
// self-checking bench for the status-indicator driver
// assumes the design's own assertions run beside it; no partner model
module test_status_indicators
	import indicator_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ***************************************************
	// signals and instance
	// ***************************************************
	localparam int unsigned HALF = 4;
	localparam logic [6:0] SEG_TBL [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
		7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	op_mode_t    mode_i     = MODE_INIT;
	logic        debug_running_i  = 1'b0;
	logic        fatal_fault_i    = 1'b0;
	logic        prog_halt_err_i  = 1'b0;
	logic        prog_local_err_i = 1'b0;
	logic        validated_i      = 1'b0;
	logic        sig_confirmed_i  = 1'b0;
	logic [7:0]  sig_byte_i       = 8'h00;
	logic        conn_pending_i   = 1'b0;
	logic [7:0]  addr_i           = 8'h00;
	logic [31:0] wdata_i          = 32'h0000_0000;
	logic        wr_i             = 1'b0;
	logic        rd_i             = 1'b0;
	logic [31:0] rdata_o;
	logic        irq_o;
	logic        perr_lamp_o;
	logic        run_lamp_o;
	logic        debug_lamp_o;
	logic        valid_lamp_o;
	logic [6:0]  seg_hi_o;
	logic [6:0]  seg_lo_o;
	int          n_mismatch = 0;
	int          cmp_count  = 0;

	status_indicators #(.HALF_CYCLES(HALF)) DUT (
		.core_clk_i       (core_clk_i),
		.rst_i            (rst_i),
		.mode_i           (mode_i),
		.debug_running_i  (debug_running_i),
		.fatal_fault_i    (fatal_fault_i),
		.prog_halt_err_i  (prog_halt_err_i),
		.prog_local_err_i (prog_local_err_i),
		.validated_i      (validated_i),
		.sig_confirmed_i  (sig_confirmed_i),
		.sig_byte_i       (sig_byte_i),
		.conn_pending_i   (conn_pending_i),
		.addr_i           (addr_i),
		.wdata_i          (wdata_i),
		.wr_i             (wr_i),
		.rd_i             (rd_i),
		.rdata_o          (rdata_o),
		.irq_o            (irq_o),
		.perr_lamp_o      (perr_lamp_o),
		.run_lamp_o       (run_lamp_o),
		.debug_lamp_o     (debug_lamp_o),
		.valid_lamp_o     (valid_lamp_o),
		.seg_hi_o         (seg_hi_o),
		.seg_lo_o         (seg_lo_o)
	);

	always #2 core_clk_i = ~core_clk_i;

	// ***************************************************
	// shared tasks
	// ***************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	task automatic results();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		results();
	end

	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		logic [3:0] b;
		logic [3:0] exp_l;
		logic [7:0] sb;
		op_mode_t   m;
		int         ones;
		repeat (8) @(posedge core_clk_i);
		#1;
		chk({perr_lamp_o, run_lamp_o, debug_lamp_o, valid_lamp_o, seg_hi_o, seg_lo_o}, 0);
		@(posedge core_clk_i);
		rst_i <= 1'b0;
		// steady lamp and display table
		for (int i = 0; i < 48; i++) begin
			b  = 4'(i / 3);
			m  = (i % 3 == 0) ? MODE_RUN : (i % 3 == 1) ? MODE_PROGRAM : MODE_DEBUG;
			sb = 8'(i * 37);
			@(posedge core_clk_i);
			mode_i           <= m;
			debug_running_i  <= b[0];
			fatal_fault_i    <= b[1];
			validated_i      <= b[2];
			prog_halt_err_i  <= b[3];
			prog_local_err_i <= b[3];
			sig_confirmed_i  <= i[0];
			sig_byte_i       <= sb;
			@(posedge core_clk_i);
			#1;
			exp_l[3] = b[3];
			exp_l[2] = !b[1] && (m == MODE_RUN || (m == MODE_DEBUG && b[0]));
			exp_l[1] = !b[1] && m == MODE_DEBUG;
			exp_l[0] = b[2] && !b[1];
			chk({perr_lamp_o, run_lamp_o, debug_lamp_o, valid_lamp_o}, exp_l);
			chk({seg_hi_o, seg_lo_o}, i[0] ? {SEG_TBL[sb[7:4]], SEG_TBL[sb[3:0]]} : 14'h2040);
		end
		// flashing: init run lamp, local error, pending connection
		@(posedge core_clk_i);
		mode_i           <= MODE_INIT;
		fatal_fault_i    <= 1'b0;
		prog_halt_err_i  <= 1'b0;
		prog_local_err_i <= 1'b1;
		sig_confirmed_i  <= 1'b1;
		sig_byte_i       <= 8'h3a;
		conn_pending_i   <= 1'b1;
		@(posedge core_clk_i);
		ones = 0;
		for (int k = 0; k < 2 * HALF; k++) begin
			@(posedge core_clk_i);
			#1;
			ones += int'(run_lamp_o === 1'b1);
			chk(perr_lamp_o, run_lamp_o);
			chk({seg_hi_o, seg_lo_o}, run_lamp_o ? {SEG_TBL[3], SEG_TBL[10]} : 14'h0000);
		end
		chk(ones, HALF);
		// connections up: display steady
		@(posedge core_clk_i);
		conn_pending_i   <= 1'b0;
		prog_local_err_i <= 1'b0;
		mode_i           <= MODE_RUN;
		sig_confirmed_i  <= 1'b0;
		@(posedge core_clk_i);
		for (int k = 0; k < 2 * HALF; k++) begin
			@(posedge core_clk_i);
			#1;
			chk({perr_lamp_o, run_lamp_o, seg_hi_o, seg_lo_o}, 16'h6040);
		end
		// register port, events and interrupt
		wr(REG_EVENT, 32'h0000_001f);
		rd(REG_EVENT, 32'h0000_0000);
		rd(REG_MASK, 32'h0000_0000);
		rd(REG_CTRL, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		wr(8'h10, 32'hffff_ffff);
		wr(REG_MASK, 32'h0000_0001);
		rd(REG_MASK, 32'h0000_0001);
		chk(irq_o, 1'b0);
		@(posedge core_clk_i);
		prog_halt_err_i <= 1'b1;
		@(posedge core_clk_i);
		#1;
		chk(irq_o, 1'b1);
		rd(REG_EVENT, 32'h0000_0001);
		wr(REG_MASK, 32'h0000_0000);
		chk(irq_o, 1'b0);
		wr(REG_MASK, 32'h0000_0001);
		chk(irq_o, 1'b1);
		wr(REG_EVENT, 32'h0000_0001);
		chk(irq_o, 1'b0);
		rd(REG_EVENT, 32'h0000_0000);
		// display blanking through control
		wr(REG_CTRL, 32'h0000_0001);
		@(posedge core_clk_i);
		#1;
		chk({seg_hi_o, seg_lo_o}, 14'h0000);
		wr(REG_CTRL, 32'h0000_0000);
		@(posedge core_clk_i);
		#1;
		chk({seg_hi_o, seg_lo_o}, 14'h2040);
		// status word, flash phase bit masked
		@(posedge core_clk_i);
		rd_i   <= 1'b1;
		addr_i <= REG_STATUS;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o & 32'hffff_ffbf, 32'h0080_3a1b);
		// later events, masked from the interrupt
		@(posedge core_clk_i);
		mode_i           <= MODE_PROGRAM;
		fatal_fault_i    <= 1'b1;
		prog_local_err_i <= 1'b1;
		conn_pending_i   <= 1'b1;
		@(posedge core_clk_i);
		conn_pending_i <= 1'b0;
		rd(REG_EVENT, 32'h0000_001e);
		chk(irq_o, 1'b0);
		wr(REG_MASK, 32'h0000_0010);
		chk(irq_o, 1'b1);
		chk({perr_lamp_o, run_lamp_o, debug_lamp_o, valid_lamp_o}, 4'h8);
		results();
	end
endmodule
